// ### heat_seq_pkg.sv
// Package for the sensing element heating sequencer.
package heat_seq_pkg;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned SEC_CYCLES = CLK_HZ;
   localparam int unsigned CYCLIC_INTERVAL_S = 24 * 3600;
   localparam int unsigned HEAT_DEFAULT_MIN = 20;
   localparam int unsigned COOL_DEFAULT_MIN = 3;
   localparam int unsigned GUARD_PULSE_S = 10;
   localparam int unsigned GUARD_COOL_MIN = 3;
   localparam int unsigned GUARD_LOCK_DEFAULT_MIN = 30;
   localparam logic [31:0] HEAT_DEFAULT_S = 32'(HEAT_DEFAULT_MIN * 60);
   localparam logic [31:0] COOL_DEFAULT_S = 32'(COOL_DEFAULT_MIN * 60);
   localparam logic [31:0] CYCLIC_DEFAULT_S = 32'(CYCLIC_INTERVAL_S);
   localparam logic [31:0] GUARD_LOCK_DEFAULT_S =
      32'(GUARD_LOCK_DEFAULT_MIN * 60);
   localparam logic [31:0] GUARD_PULSE_SECS = 32'(GUARD_PULSE_S);
   localparam logic [31:0] GUARD_COOL_SECS = 32'(GUARD_COOL_MIN * 60);
   // ------------------------------------------------------------------
   // Widths and modes
   // ------------------------------------------------------------------
   localparam int unsigned MEAS_W = 16;
   typedef enum logic [1:0] {
      MODE_NONE, MODE_CONDENSATION_GUARD, MODE_HIGH_HUMIDITY
   } heat_mode_t;
   typedef struct packed {
      logic [MEAS_W-1:0] humidity;
      logic [MEAS_W-1:0] temperature;
   } meas_t;
   typedef struct packed {
      logic manual;
      logic modbus;
      logic external;
   } start_req_t;
endpackage

// ### heat_seq.sv
// Sensing element heating sequencer: recovery, condensation and humidity guard.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Manual start request begins recovery heating.
// - Cyclic mode restarts recovery at configured interval.
// - Optional recovery start at power-on, only when cyclic mode is also enabled.
// - Modbus command or external input starts recovery.
// - Recovery first heats for configured duration.
// - Then cools with heater off, configured duration.
// - Outputs frozen for whole recovery cycle.
// - Status LED lit through whole recovery.
// - Remaining recovery seconds counted down for readout.
// - Guard pulse starts when humidity reaches setpoint.
// - Guard pulse heats ten seconds.
// - Guard cool-down about three minutes follows.
// - Persistent condensation restarts guard after lock.
// - Outputs frozen during guard heating and cooling.
// - Lock time blocks new guard pulses after guard cool-down.
// - Lock time is a configuration input.
// - High-humidity mode keeps dual heating on, except element heat is off during recovery cool-down.
// - Serial Modbus may change only communication settings.
module heat_seq
   import heat_seq_pkg::*;
#(
   parameter logic [31:0] SEC_TICKS = 32'(SEC_CYCLES)
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   // Configuration
   input wire heat_mode_t MODE,
   input wire logic CYCLIC_EN,
   input wire logic POWER_ON_EN,
   input wire logic [31:0] CYCLIC_S,
   input wire logic [31:0] HEAT_S,
   input wire logic [31:0] COOL_S,
   input wire logic [31:0] LOCK_S,
   input wire logic [MEAS_W-1:0] RH_SETPOINT,
   // Start requests, pulses from core logic except the external pin
   input wire start_req_t START_REQ,
   input wire logic EXT_TRIGGER_PIN,
   // Serial Modbus configuration writes
   input wire logic SER_CFG_WR,
   input wire logic SER_CFG_IS_COMM,
   output logic SER_CFG_ACCEPT,
   // Measurements
   input wire meas_t MEAS_IN,
   output meas_t MEAS_OUT,
   // Heating and status
   output logic ELEMENT_HEAT,
   output logic BODY_HEAT,
   output logic RECOVERY_STATUS_LED,
   output logic RECOVERY_ACTIVE,
   output logic [31:0] RECOVERY_REMAIN_S
);
   // ------------------------------------------------------------------
   // Pin synchroniser and second tick
   // ------------------------------------------------------------------
   logic [2:0] ext_sync_r, ext_sync_nxt;
   logic ext_level_r, ext_level_nxt;
   logic [31:0] tick_cnt_r, tick_cnt_nxt;
   logic sec_tick;
   logic ext_rise;

   always_comb begin
      ext_sync_nxt = {ext_sync_r[1:0], EXT_TRIGGER_PIN};
      ext_level_nxt = ext_level_r;
      if (ext_sync_r[1] == ext_sync_r[2]) begin
         ext_level_nxt = ext_sync_r[2];
      end
      sec_tick = (tick_cnt_r == SEC_TICKS - 32'h0000_0001);
      tick_cnt_nxt = sec_tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
   end
   assign ext_rise = ext_level_nxt & ~ext_level_r;

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ext_sync_r <= 3'h0;
         ext_level_r <= 1'b0;
         tick_cnt_r <= 32'h0000_0000;
      end else begin
         ext_sync_r <= ext_sync_nxt;
         ext_level_r <= ext_level_nxt;
         tick_cnt_r <= tick_cnt_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Recovery sequencer
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {REC_IDLE, REC_HEAT, REC_COOL} rec_state_t;
   rec_state_t rec_r, rec_nxt;
   logic [31:0] rec_cnt_r, rec_cnt_nxt;
   logic [31:0] rec_remain_r, rec_remain_nxt;
   logic [31:0] cyc_cnt_r, cyc_cnt_nxt;
   logic boot_r, boot_nxt;
   logic rec_start;
   logic cyc_due;

   always_comb begin
      rec_nxt = rec_r;
      rec_cnt_nxt = rec_cnt_r;
      rec_remain_nxt = rec_remain_r;
      cyc_cnt_nxt = cyc_cnt_r;
      boot_nxt = 1'b0;
      cyc_due = 1'b0;
      if (CYCLIC_EN) begin
         if (sec_tick) begin
            cyc_cnt_nxt = cyc_cnt_r + 32'h0000_0001;
         end
         if (cyc_cnt_r >= CYCLIC_S && CYCLIC_S != 32'h0000_0000) begin
            cyc_due = 1'b1;
            cyc_cnt_nxt = 32'h0000_0000;
         end
      end else begin
         cyc_cnt_nxt = 32'h0000_0000;
      end
      rec_start = START_REQ.manual | START_REQ.modbus
         | ext_rise | cyc_due
         | (boot_r & CYCLIC_EN & POWER_ON_EN);
      unique case (rec_r)
         REC_IDLE: begin
            if (rec_start) begin
               rec_nxt = REC_HEAT;
               rec_cnt_nxt = HEAT_S;
               rec_remain_nxt = HEAT_S + COOL_S;
            end
         end
         REC_HEAT: begin
            // Further start requests fall through untouched.
            if (sec_tick) begin
               rec_remain_nxt = rec_remain_r - 32'h0000_0001;
               rec_cnt_nxt = rec_cnt_r - 32'h0000_0001;
            end
            if (rec_cnt_r == 32'h0000_0000) begin
               rec_nxt = REC_COOL;
               rec_cnt_nxt = COOL_S;
            end
         end
         REC_COOL: begin
            if (sec_tick && rec_remain_r != 32'h0000_0000) begin
               rec_remain_nxt = rec_remain_r - 32'h0000_0001;
            end
            if (sec_tick) begin
               rec_cnt_nxt = rec_cnt_r - 32'h0000_0001;
            end
            if (rec_cnt_r == 32'h0000_0000) begin
               rec_nxt = REC_IDLE;
               rec_remain_nxt = 32'h0000_0000;
            end
         end
         default: rec_nxt = REC_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rec_r <= REC_IDLE;
         rec_cnt_r <= 32'h0000_0000;
         rec_remain_r <= 32'h0000_0000;
         cyc_cnt_r <= 32'h0000_0000;
         boot_r <= 1'b1;
      end else begin
         rec_r <= rec_nxt;
         rec_cnt_r <= rec_cnt_nxt;
         rec_remain_r <= rec_remain_nxt;
         cyc_cnt_r <= cyc_cnt_nxt;
         boot_r <= boot_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Condensation guard
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {CG_IDLE, CG_PULSE, CG_COOL, CG_LOCK} cg_state_t;
   cg_state_t cg_r, cg_nxt;
   logic [31:0] cg_cnt_r, cg_cnt_nxt;
   logic wet;

   // Recovery takes priority; an idle guard starts no pulse while it runs.
   always_comb begin
      cg_nxt = cg_r;
      cg_cnt_nxt = cg_cnt_r;
      wet = MEAS_IN.humidity >= RH_SETPOINT;
      if (sec_tick && cg_cnt_r != 32'h0000_0000) begin
         cg_cnt_nxt = cg_cnt_r - 32'h0000_0001;
      end
      unique case (cg_r)
         CG_IDLE: begin
            if (MODE == MODE_CONDENSATION_GUARD && wet
                && rec_r == REC_IDLE) begin
               cg_nxt = CG_PULSE;
               cg_cnt_nxt = GUARD_PULSE_SECS;
            end
         end
         CG_PULSE: begin
            if (cg_cnt_r == 32'h0000_0000) begin
               cg_nxt = CG_COOL;
               cg_cnt_nxt = GUARD_COOL_SECS;
            end
         end
         CG_COOL: begin
            if (cg_cnt_r == 32'h0000_0000) begin
               cg_nxt = CG_LOCK;
               cg_cnt_nxt = LOCK_S;
            end
         end
         CG_LOCK: begin
            // A zero lock time restarts at once if still wet.
            if (cg_cnt_r == 32'h0000_0000) begin
               cg_nxt = CG_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cg_r <= CG_IDLE;
         cg_cnt_r <= 32'h0000_0000;
      end else begin
         cg_r <= cg_nxt;
         cg_cnt_r <= cg_cnt_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs and frozen measurements
   // ------------------------------------------------------------------
   meas_t meas_r, meas_nxt;
   logic freeze;
   logic freeze_nxt;
   logic heat_r, heat_nxt;
   logic body_r, body_nxt;
   logic led_r, led_nxt;
   logic acc_r, acc_nxt;

   always_comb begin
      freeze = (rec_r != REC_IDLE) || (cg_r == CG_PULSE)
         || (cg_r == CG_COOL);
      freeze_nxt = (rec_nxt != REC_IDLE) || (cg_nxt == CG_PULSE)
         || (cg_nxt == CG_COOL);
      meas_nxt = (freeze || freeze_nxt) ? meas_r : MEAS_IN;
      heat_nxt = (rec_nxt == REC_HEAT) || (cg_nxt == CG_PULSE)
         || (MODE == MODE_HIGH_HUMIDITY && rec_nxt == REC_IDLE);
      body_nxt = (MODE == MODE_HIGH_HUMIDITY);
      led_nxt = (rec_nxt != REC_IDLE);
      acc_nxt = SER_CFG_WR & SER_CFG_IS_COMM;
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         meas_r <= '0;
         heat_r <= 1'b0;
         body_r <= 1'b0;
         led_r <= 1'b0;
         acc_r <= 1'b0;
      end else begin
         meas_r <= meas_nxt;
         heat_r <= heat_nxt;
         body_r <= body_nxt;
         led_r <= led_nxt;
         acc_r <= acc_nxt;
      end
   end

   assign MEAS_OUT = meas_r;
   assign ELEMENT_HEAT = heat_r;
   assign BODY_HEAT = body_r;
   assign RECOVERY_STATUS_LED = led_r;
   assign RECOVERY_ACTIVE = led_r;
   assign RECOVERY_REMAIN_S = rec_remain_r;
   assign SER_CFG_ACCEPT = acc_r;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_led_follows;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (rec_r == REC_IDLE && $past(rec_r) == REC_IDLE) |-> !RECOVERY_STATUS_LED;
   endproperty
   a_led_follows: assert property (p_led_follows) else $error("led lit idle");
   property p_start_manual;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (rec_r == REC_IDLE && START_REQ.manual) |=> rec_r == REC_HEAT;
   endproperty
   a_start_manual: assert property (p_start_manual) else $error("no start");
   property p_start_modbus;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (rec_r == REC_IDLE && START_REQ.modbus) |=> ##1 RECOVERY_STATUS_LED;
   endproperty
   a_start_modbus: assert property (p_start_modbus) else $error("no led");
   property p_freeze;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (rec_r == REC_HEAT && $past(rec_r) == REC_HEAT) |-> $stable(MEAS_OUT);
   endproperty
   a_freeze: assert property (p_freeze) else $error("output moved");
   property p_cool_off;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (rec_r == REC_COOL && cg_r != CG_PULSE
       && rec_cnt_r != 32'h0000_0000) |=> !ELEMENT_HEAT;
   endproperty
   a_cool_off: assert property (p_cool_off) else $error("heat in cool");
   property p_cg_start;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (cg_r == CG_IDLE && MODE == MODE_CONDENSATION_GUARD && wet
       && rec_r == REC_IDLE) |=> cg_r == CG_PULSE ##1 ELEMENT_HEAT;
   endproperty
   a_cg_start: assert property (p_cg_start) else $error("no pulse");
   property p_lock_quiet;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (cg_r == CG_LOCK && rec_r == REC_IDLE && MODE != MODE_HIGH_HUMIDITY)
      |=> ##1 !ELEMENT_HEAT || rec_r != REC_IDLE || cg_r != CG_LOCK;
   endproperty
   a_lock_quiet: assert property (p_lock_quiet) else $error("heat locked");
   property p_ser_cfg;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (SER_CFG_WR && !SER_CFG_IS_COMM) |=> !SER_CFG_ACCEPT;
   endproperty
   a_ser_cfg: assert property (p_ser_cfg) else $error("cfg accepted");
   property p_no_restart;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (rec_r == REC_HEAT && START_REQ.manual && rec_cnt_r != 32'h0000_0000)
      |=> $stable(rec_remain_r) || $past(sec_tick);
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("restarted");
   property p_body;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (MODE == MODE_HIGH_HUMIDITY) [*2] |-> BODY_HEAT;
   endproperty
   a_body: assert property (p_body) else $error("body cold");
endmodule // heat_seq
`default_nettype wire

// ### probe_source_model.sv
// Probe and trigger source model facing the heating sequencer.
`timescale 1ns/1ps
`default_nettype none
module probe_source_model
   import heat_seq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Commands from the bench
   input wire logic [MEAS_W-1:0] rh_level,
   input wire logic fire,
   // Device side
   output meas_t meas,
   output logic ext_pin
);
   logic [MEAS_W-1:0] temp_r;
   int hold_r;
   // Temperature drifts every cycle so that a frozen output shows.
   // The pin is held long enough to pass any input debounce.
   // Sampling on the rising edge keeps clear of the bench's falling-edge
   // stimulus, so a one-cycle fire request is never lost to a race.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         temp_r <= 16'h0000;
         hold_r <= 0;
      end else begin
         temp_r <= temp_r + 16'h0001;
         hold_r <= fire ? 100 : (hold_r > 0 ? hold_r - 1 : 0);
      end
   end
   assign meas = '{humidity: rh_level, temperature: temp_r};
   assign ext_pin = (hold_r > 0);
endmodule // probe_source_model
`default_nettype wire

// ### sensor_heating_mode_sequencer_tb_top.sv
// Self-checking bench for the heating sequencer.
`timescale 1ns/1ps
`default_nettype none
module sensor_heating_mode_sequencer_tb_top
   import heat_seq_pkg::*;
;
   logic clk = 0, rst = 1, cyc_en = 0, pon_en = 0, wr = 0, comm = 0;
   logic fire = 0, ext_pin, accept, heat, body, led, active;
   heat_mode_t mode = MODE_NONE;
   logic [31:0] cyc_s = 32'h0000_0008, remain;
   logic [MEAS_W-1:0] rh = 16'h0010;
   start_req_t req = '0;
   meas_t meas_in, meas_out, held;
   int mismatches = 0, samples_checked = 0, n;
   always #2.5 clk = ~clk;
   heat_seq #(.SEC_TICKS(32'h0000_000A)) uut (.CORE_CLK(clk),
      .SYS_RST(rst), .MODE(mode), .CYCLIC_EN(cyc_en), .POWER_ON_EN(pon_en),
      .CYCLIC_S(cyc_s), .HEAT_S(32'h0000_0004), .COOL_S(32'h0000_0002),
      .LOCK_S(32'h0000_0032), .RH_SETPOINT(16'h0064), .START_REQ(req),
      .EXT_TRIGGER_PIN(ext_pin), .SER_CFG_WR(wr), .SER_CFG_IS_COMM(comm),
      .SER_CFG_ACCEPT(accept), .MEAS_IN(meas_in), .MEAS_OUT(meas_out),
      .ELEMENT_HEAT(heat), .BODY_HEAT(body), .RECOVERY_STATUS_LED(led),
      .RECOVERY_ACTIVE(active), .RECOVERY_REMAIN_S(remain));
   probe_source_model partner (.clk(clk), .rst(rst), .rh_level(rh),
      .fire(fire), .meas(meas_in), .ext_pin(ext_pin));
   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic step(input int c);
      repeat (c) @(negedge clk);
   endtask
   // Waits a bounded time for the lamp (sel 0) or heater (sel 1).
   task automatic wait_on(input int sel, input logic want, input int lim);
      n = 0;
      while (((sel == 1) ? heat : led) !== want && n < lim) begin
         step(1);
         n++;
      end
      check(n < lim, 1, "wait ran out");
   endtask
   task automatic pulse(input int kind);
      step(1);
      if (kind == 0) req.manual = 1;
      else req.modbus = 1;
      step(1);
      req = '0;
   endtask
   task automatic do_reset();
      rst = 1;
      step(5);
      rst = 0;
   endtask
   task automatic test_done();
      $display("mismatches=%0d checks=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_manual();
      pulse(0);
      wait_on(0, 1, 4);
      held = meas_out;
      check(heat, 1, "heating phase");
      check(active, 1, "active flag off");
      check(remain, 32'h0000_0006, "remaining seconds");
      step(24);
      pulse(0);
      step(16);
      check(heat, 0, "heater on in cool-down");
      check(led, 1, "lamp off early");
      check(meas_out, held, "output moved");
      check(remain < 6 && remain > 0, 1, "remaining not counting");
      step(24);
      check(led, 0, "second start not ignored");
      check(active, 0, "active flag stuck");
      check(meas_out != held, 1, "output still frozen");
   endtask
   task automatic t_remote();
      pulse(1);
      wait_on(0, 1, 4);
      wait_on(0, 0, 80);
      fire = 1;
      step(1);
      fire = 0;
      wait_on(0, 1, 150);
      wait_on(0, 0, 80);
   endtask
   task automatic t_cyclic();
      cyc_en = 1;
      wait_on(0, 1, 100);
      wait_on(0, 0, 80);
      wait_on(0, 1, 100);
      pon_en = 1;
      do_reset();
      wait_on(0, 1, 4);
      cyc_en = 0;
      pon_en = 0;
      wait_on(0, 0, 80);
   endtask
   task automatic t_guard();
      mode = MODE_CONDENSATION_GUARD;
      rh = 16'h0063;
      step(30);
      check(heat, 0, "heating below setpoint");
      rh = 16'h0064;
      wait_on(1, 1, 4);
      held = meas_out;
      step(85);
      check(heat, 1, "pulse too short");
      step(25);
      check(heat, 0, "pulse too long");
      check(led, 0, "lamp lit by guard");
      step(1590);
      check(heat, 0, "heated in cool-down");
      check(meas_out, held, "output moved");
      wait_on(1, 1, 900);
      check(n > 650 && n < 800, 1, "lock time not kept");
      rh = 16'h0010;
      mode = MODE_NONE;
      wait_on(1, 0, 120);
   endtask
   task automatic t_high_and_serial();
      mode = MODE_HIGH_HUMIDITY;
      wait_on(1, 1, 4);
      step(20);
      check({heat, body}, 2'b11, "dual heating off");
      mode = MODE_NONE;
      for (int c = 1; c >= 0; c--) begin
         wr = 1;
         comm = c[0];
         step(1);
         wr = 0;
         check(accept, c[0], "serial write acceptance");
         step(1);
      end
   endtask
   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      do_reset();
      t_manual();
      t_remote();
      t_cyclic();
      t_guard();
      t_high_and_serial();
      test_done();
   end
   initial begin
      #60us;
      mismatches++;
      test_done();
   end
endmodule // sensor_heating_mode_sequencer_tb_top
`default_nettype wire
